// file: rtl/cpsr_top.sv
// Purpose: Charge period and setup register bank with interval timing.
// Assumes: Host pins are asynchronous; charge_active is on core_clk.
// Notes: Reads and writes go through a command byte sent with select low.
`timescale 1ns/1ps
`default_nettype none
`include "cpsr_params.svh"
module cpsr_top #(
  parameter int SEG_CYCLES = `CPSR_SEG_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire cpsr_pkg::cpsr_host_t host_in,
  output logic [7:0] host_data_o,
  output logic host_data_oe,
  input wire cpsr_pkg::cpsr_stat_t stat_in,
  input wire logic [11:0] batt_voltage,
  input wire logic charge_active,
  output logic charge_drive_q,
  output logic discharge_drive_q,
  output logic seg_tick_q,
  output logic [7:0] seg_count_q,
  output logic [11:0] cell_voltage_q,
  output cpsr_pkg::cpsr_limits_t limits_q,
  output logic [7:0] setup_one_q,
  output logic [7:0] setup_two_q,
  output logic [7:0] max_charge_time_q,
  output logic [7:0] trickle_period_q,
  output logic [7:0] output_mask_q,
  output logic [7:0] output_control_q,
  output logic [15:0] gauge_threshold_q,
  output logic cmd_sys_off_q,
  output logic cmd_start_q,
  output logic cmd_abort_q
);
  import cpsr_pkg::*;

  if (SEG_CYCLES < 1)
  begin : g_bad_seg
    $error("SEG_CYCLES must be at least one.");
  end

  // Writable bits of each byte; status bits and gauges are read-only.
  function automatic logic [7:0] cpsr_wmask(input logic [4:0] a);
    case (a)
      `CPSR_A_SETUP_TWO: cpsr_wmask = `CPSR_SETUP2_WMASK;
      `CPSR_A_GAUGE_HI, `CPSR_A_GAUGE_LO: cpsr_wmask = 8'h00;
      `CPSR_A_LAST_HI, `CPSR_A_LAST_LO: cpsr_wmask = 8'h00;
      `CPSR_A_STATUS: cpsr_wmask = 8'h00;
      default: cpsr_wmask = (a <= `CPSR_A_TRICKLE) ? 8'hFF : 8'h00;
    endcase
  endfunction : cpsr_wmask

  // Scale factor actually used; a stray 0 or >10 cannot blow up the math.
  function automatic logic [3:0] cpsr_cells(input logic [7:0] setup);
    logic [3:0] n;
    n = setup[`CPSR_CELLS_MSB:`CPSR_CELLS_LSB];
    if (n < `CPSR_CELLS_MIN)
      cpsr_cells = `CPSR_CELLS_MIN;
    else if (n > `CPSR_CELLS_MAX)
      cpsr_cells = `CPSR_CELLS_MAX;
    else
      cpsr_cells = n;
  endfunction : cpsr_cells

  cpsr_host_t s1_q;
  cpsr_host_t s2_q;
  cpsr_host_t s3_q;
  cpsr_host_t filt_q;
  cpsr_host_t filt_d;
  cpsr_acc_t acc_q;
  cpsr_acc_t acc_d;
  logic [4:0] addr_q;
  logic [4:0] addr_d;
  logic [7:0] dout_d;
  logic oe_d;
  logic off_d;
  logic start_d;
  logic abort_d;
  logic wr_end;
  logic rd_start;
  logic rd_end;
  logic reg_we;
  logic ram_we;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] regs_q [`CPSR_REG_COUNT];
  logic [7:0] regs_d [`CPSR_REG_COUNT];
  logic [7:0] ram_q [`CPSR_RAM_DEPTH];
  logic [7:0] chg_period;
  logic [7:0] dis_period;
  logic [3:0] cells;
  logic chg_en;
  logic chg_d;
  logic dis_d;
  logic [11:0] cellv_d;
  cpsr_limits_t lim_d;
  logic [7:0] seg_count;
  logic seg_tick;

  cpsr_seg_timer #(
    .SEG_CYCLES(SEG_CYCLES)
  ) u_seg (
    .core_clk(core_clk),
    .rst(rst),
    .seg_tick_q(seg_tick),
    .seg_count_q(seg_count)
  );

  // Pin filter: a bit changes only when stages two and three agree.
  always_comb
  begin
    filt_d = cpsr_host_t'((s2_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q)));
    wr_end = filt_d.wr_n & ~filt_q.wr_n;
    rd_start = ~filt_d.rd_n & filt_q.rd_n;
    rd_end = filt_d.rd_n & ~filt_q.rd_n;
    wdata = filt_q.data;
  end

  // Read data; unmapped register bytes read as zero.
  always_comb
  begin
    rdata = 8'h00;
    if (acc_q == ACC_RD_RAM)
      rdata = ram_q[addr_q];
    else
    begin
      case (addr_q)
        `CPSR_A_SETUP_TWO: rdata = {stat_in.br, stat_in.gauge_invalid_flag,
          regs_q[`CPSR_A_SETUP_TWO][5:0]};
        `CPSR_A_GAUGE_HI: rdata = stat_in.gauge[15:8];
        `CPSR_A_GAUGE_LO: rdata = stat_in.gauge[7:0];
        `CPSR_A_LAST_HI: rdata = stat_in.last_cap[15:8];
        `CPSR_A_LAST_LO: rdata = stat_in.last_cap[7:0];
        `CPSR_A_STATUS: rdata = stat_in.status;
        default:
        begin
          if (addr_q <= `CPSR_A_TRICKLE)
            rdata = regs_q[addr_q];
        end
      endcase
    end
  end

  // Command byte arms one data access; direct commands give one pulse.
  always_comb
  begin
    acc_d = acc_q;
    addr_d = addr_q;
    dout_d = host_data_o;
    oe_d = host_data_oe;
    off_d = 1'b0;
    start_d = 1'b0;
    abort_d = 1'b0;
    reg_we = 1'b0;
    ram_we = 1'b0;
    if (wr_end && !filt_q.sel_data)
    begin
      addr_d = wdata[4:0];
      case (wdata[7:5])
        `CPSR_CMD_WR_REG: acc_d = ACC_WR_REG;
        `CPSR_CMD_RD_REG: acc_d = ACC_RD_REG;
        `CPSR_CMD_WR_RAM: acc_d = ACC_WR_RAM;
        `CPSR_CMD_RD_RAM: acc_d = ACC_RD_RAM;
        `CPSR_CMD_SYS_OFF:
        begin
          acc_d = ACC_IDLE;
          off_d = 1'b1;
        end
        `CPSR_CMD_START:
        begin
          acc_d = ACC_IDLE;
          start_d = 1'b1;
        end
        `CPSR_CMD_ABORT:
        begin
          acc_d = ACC_IDLE;
          abort_d = 1'b1;
        end
        default: acc_d = ACC_IDLE;
      endcase
    end
    else if (wr_end && filt_q.sel_data)
    begin
      reg_we = (acc_q == ACC_WR_REG);
      ram_we = (acc_q == ACC_WR_RAM);
      acc_d = ACC_IDLE;
    end
    else if (rd_start && filt_q.sel_data)
    begin
      if (acc_q == ACC_RD_REG || acc_q == ACC_RD_RAM)
      begin
        dout_d = rdata;
        oe_d = 1'b1;
      end
    end
    else if (rd_end)
    begin
      oe_d = 1'b0;
      if (host_data_oe)
        acc_d = ACC_IDLE;
    end
  end

  // Pin stages, sequencer and command pulses.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= cpsr_host_t'(`CPSR_HOST_IDLE);
      s2_q <= cpsr_host_t'(`CPSR_HOST_IDLE);
      s3_q <= cpsr_host_t'(`CPSR_HOST_IDLE);
      filt_q <= cpsr_host_t'(`CPSR_HOST_IDLE);
      acc_q <= ACC_IDLE;
      addr_q <= 5'h00;
      host_data_o <= 8'h00;
      host_data_oe <= 1'b0;
      cmd_sys_off_q <= 1'b0;
      cmd_start_q <= 1'b0;
      cmd_abort_q <= 1'b0;
    end
    else
    begin
      s1_q <= host_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
      acc_q <= acc_d;
      addr_q <= addr_d;
      host_data_o <= dout_d;
      host_data_oe <= oe_d;
      cmd_sys_off_q <= off_d;
      cmd_start_q <= start_d;
      cmd_abort_q <= abort_d;
    end
  end

  // Masked byte write; read-only bits keep their old value.
  always_comb
  begin
    regs_d = regs_q;
    if (reg_we && addr_q < 5'(`CPSR_REG_COUNT))
      regs_d[addr_q] = (regs_q[addr_q] & ~cpsr_wmask(addr_q)) |
        (wdata & cpsr_wmask(addr_q));
  end

  // Setup one resets with ten cells and charging disabled.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < `CPSR_REG_COUNT; i++)
        regs_q[i] <= 8'h00;
      regs_q[`CPSR_A_SETUP_ONE] <= `CPSR_SETUP1_RST;
    end
    else
      regs_q <= regs_d;
  end

  // Byte storage is data, not control, so it carries no reset.
  always_ff @(posedge core_clk)
  begin
    if (ram_we)
      ram_q[addr_q] <= wdata;
  end

  // Charge first, then discharge; the tail past both stays off.
  always_comb
  begin
    chg_period = regs_q[`CPSR_A_CHG_PERIOD];
    dis_period = regs_q[`CPSR_A_DIS_PERIOD];
    cells = cpsr_cells(regs_q[`CPSR_A_SETUP_ONE]);
    chg_en = regs_q[`CPSR_A_SETUP_ONE][`CPSR_EN_BIT] & charge_active;
    chg_d = chg_en && (seg_count <= chg_period);
    dis_d = chg_en && (seg_count > chg_period) &&
      ({1'b0, seg_count} <= {1'b0, chg_period} + {1'b0, dis_period});
    cellv_d = 12'(batt_voltage / {8'h00, cells});
    lim_d.edv_limit = {4'h0, regs_q[`CPSR_A_CELL_DIS]} * {8'h00, cells};
    lim_d.max_limit = {4'h0, regs_q[`CPSR_A_MAX_CELL]} * {8'h00, cells};
  end

  // Drives and scaled voltages settle one clock after their inputs.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      charge_drive_q <= 1'b0;
      discharge_drive_q <= 1'b0;
      cell_voltage_q <= 12'h000;
      limits_q <= '0;
      seg_tick_q <= 1'b0;
      seg_count_q <= 8'h00;
    end
    else
    begin
      charge_drive_q <= chg_d;
      discharge_drive_q <= dis_d;
      cell_voltage_q <= cellv_d;
      limits_q <= lim_d;
      seg_tick_q <= seg_tick;
      seg_count_q <= seg_count;
    end
  end

  // Register bytes that steer the outside world.
  assign setup_one_q = regs_q[`CPSR_A_SETUP_ONE];
  assign setup_two_q = regs_q[`CPSR_A_SETUP_TWO];
  assign max_charge_time_q = regs_q[`CPSR_A_MAX_TIME];
  assign trickle_period_q = regs_q[`CPSR_A_TRICKLE];
  assign output_mask_q = regs_q[`CPSR_A_OUT_MASK];
  assign output_control_q = regs_q[`CPSR_A_OUT_CTRL];
  assign gauge_threshold_q = {regs_q[`CPSR_A_THR_HI], regs_q[`CPSR_A_THR_LO]};

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence seq_data_write;
    acc_q == ACC_WR_REG && wr_end && filt_q.sel_data;
  endsequence

  sequence seq_read_open;
    (acc_q == ACC_RD_REG) && rd_start && filt_q.sel_data;
  endsequence

  chk_period_store: assert property (
    seq_data_write ##0 (addr_q == `CPSR_A_CHG_PERIOD)
    |=> regs_q[`CPSR_A_CHG_PERIOD] == $past(wdata))
    else $error("Charge period byte not stored.");

  chk_read_drive: assert property (
    seq_read_open |=> host_data_oe && host_data_o == $past(rdata))
    else $error("Register read not driven.");

  chk_cells_reset: assert property (
    $past(rst) |-> regs_q[`CPSR_A_SETUP_ONE] == `CPSR_SETUP1_RST)
    else $error("Cell count not ten after reset.");

  chk_full_charge: assert property (
    (chg_en && chg_period == `CPSR_FULL_PERIOD) [*2]
    |-> charge_drive_q && !discharge_drive_q)
    else $error("Full period did not charge continuously.");

  chk_first_seg: assert property (
    (chg_en && seg_count == 8'h00) |=> charge_drive_q)
    else $error("Segment zero did not charge.");

  chk_tail_free: assert property (
    (seg_count > chg_period) |=> !charge_drive_q)
    else $error("Charge ran past its period.");

  chk_no_overlap: assert property (
    !(charge_drive_q && discharge_drive_q))
    else $error("Charge and discharge overlap.");

  chk_seg_wrap: assert property (
    (seg_tick && seg_count == 8'h00) |-> $past(seg_count) == `CPSR_SEG_LAST)
    else $error("Segment counter did not wrap at 256.");

  chk_limit_scale: assert property (
    $stable(regs_q[`CPSR_A_CELL_DIS]) && $stable(cells)
    |=> limits_q.edv_limit == 12'({4'h0, $past(regs_q[`CPSR_A_CELL_DIS])}
      * {8'h00, $past(cells)}))
    else $error("Discharge limit not cells times per-cell value.");

  chk_cell_volt: assert property (
    ##1 ({4'h0, cell_voltage_q} * {12'h000, $past(cells)}) <=
      {4'h0, $past(batt_voltage)})
    else $error("Cell voltage above its share.");

  chk_cell_field: assert property (
    (regs_q[`CPSR_A_SETUP_ONE][`CPSR_CELLS_MSB:`CPSR_CELLS_LSB] >=
      `CPSR_CELLS_MIN &&
     regs_q[`CPSR_A_SETUP_ONE][`CPSR_CELLS_MSB:`CPSR_CELLS_LSB] <=
      `CPSR_CELLS_MAX)
    |-> cells == regs_q[`CPSR_A_SETUP_ONE][`CPSR_CELLS_MSB:`CPSR_CELLS_LSB])
    else $error("Cell scale does not follow the cell field.");
endmodule : cpsr_top
`default_nettype wire

// file: rtl/cpsr_params.svh
// Purpose: Constants of the charge period and setup register bank.
// Assumes: A 200 MHz core clock and byte-wide host access.
// Notes: Definitions only; shared by the package and the modules.
// Operation
// - The bank runs repeating eight-second intervals cut into 256 segments.
// - The charge period lasts the programmed value plus one segment.
// - A charge period of FFh charges through every whole interval.
// - A charge period below FFh leaves the rest of the interval free.
// - Setup one holds qualify, enable, discharge method and cell count.
// - The cell count sits in bits 3 to 0 of setup one as a scale factor.
// - The cell count turns battery voltage into a single-cell voltage.
// - The cell count resets to 10 and software writes only 1 to 10.
// - The voltage limits are the cell count times the per-cell values.
// - Charging ends before discharging starts and takes precedence.
`ifndef CPSR_PARAMS_SVH
`define CPSR_PARAMS_SVH
`define CPSR_CLK_MHZ 200
`define CPSR_INTERVAL_US 8000000
`define CPSR_SEGMENTS 256
`define CPSR_SEG_CYCLES ((`CPSR_INTERVAL_US*`CPSR_CLK_MHZ)/`CPSR_SEGMENTS)
`define CPSR_REG_COUNT 17
`define CPSR_RAM_DEPTH 32
`define CPSR_HOST_IDLE 11'h300
`define CPSR_A_CHG_PERIOD 5'h00
`define CPSR_A_SETUP_ONE 5'h01
`define CPSR_A_SETUP_TWO 5'h02
`define CPSR_A_DIS_PERIOD 5'h03
`define CPSR_A_CELL_DIS 5'h04
`define CPSR_A_GAUGE_HI 5'h05
`define CPSR_A_GAUGE_LO 5'h06
`define CPSR_A_THR_HI 5'h07
`define CPSR_A_THR_LO 5'h08
`define CPSR_A_LAST_HI 5'h09
`define CPSR_A_LAST_LO 5'h0A
`define CPSR_A_MAX_TIME 5'h0B
`define CPSR_A_MAX_CELL 5'h0C
`define CPSR_A_OUT_MASK 5'h0D
`define CPSR_A_OUT_CTRL 5'h0E
`define CPSR_A_STATUS 5'h0F
`define CPSR_A_TRICKLE 5'h10
`define CPSR_CMD_NOP 3'h0
`define CPSR_CMD_SYS_OFF 3'h1
`define CPSR_CMD_RD_RAM 3'h2
`define CPSR_CMD_RD_REG 3'h3
`define CPSR_CMD_WR_RAM 3'h4
`define CPSR_CMD_WR_REG 3'h5
`define CPSR_CMD_START 3'h6
`define CPSR_CMD_ABORT 3'h7
`define CPSR_QUAL_BIT 7
`define CPSR_EN_BIT 6
`define CPSR_DM_MSB 5
`define CPSR_DM_LSB 4
`define CPSR_CELLS_MSB 3
`define CPSR_CELLS_LSB 0
`define CPSR_BR_BIT 7
`define CPSR_GAUGE_INVALID_FLAG_BIT 6
`define CPSR_SETUP1_RST 8'h0A
`define CPSR_SETUP2_WMASK 8'h0F
`define CPSR_CELLS_MIN 4'h1
`define CPSR_CELLS_MAX 4'hA
`define CPSR_FULL_PERIOD 8'hFF
`define CPSR_SEG_LAST 8'hFF
`endif

// file: rtl/cpsr_pkg.sv
// Purpose: Types shared by the charge period and setup register bank.
// Assumes: The constants header is on the include path.
// Notes: Host pins travel as one packed struct.
`include "cpsr_params.svh"
package cpsr_pkg;
  // Host pins: data select, active-low strobes and the data byte.
  typedef struct packed {
    logic sel_data;
    logic wr_n;
    logic rd_n;
    logic [7:0] data;
  } cpsr_host_t;

  // Status from the gauge and charge logic shown in read-only bytes.
  typedef struct packed {
    logic [7:0] status;
    logic [15:0] gauge;
    logic [15:0] last_cap;
    logic br;
    logic gauge_invalid_flag;
  } cpsr_stat_t;

  // Voltage limits scaled up to the whole battery.
  typedef struct packed {
    logic [11:0] edv_limit;
    logic [11:0] max_limit;
  } cpsr_limits_t;

  // Access sequencer after a command byte.
  typedef enum logic [2:0] {
    ACC_IDLE,
    ACC_WR_REG,
    ACC_RD_REG,
    ACC_WR_RAM,
    ACC_RD_RAM
  } cpsr_acc_t;
endpackage : cpsr_pkg

// file: rtl/cpsr_seg_timer.sv
// Purpose: Segment divider and wrapping segment counter.
// Assumes: SEG_CYCLES core clocks make one of 256 segments.
// Notes: Shorten SEG_CYCLES in simulation.
`timescale 1ns/1ps
`default_nettype none
`include "cpsr_params.svh"
module cpsr_seg_timer #(
  parameter int SEG_CYCLES = `CPSR_SEG_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  output logic seg_tick_q,
  output logic [7:0] seg_count_q
);
  localparam int CW = (SEG_CYCLES > 1) ? $clog2(SEG_CYCLES) : 1;
  localparam logic [CW-1:0] DIV_LAST = CW'(SEG_CYCLES - 1);

  // A zero-length segment would stall the interval for good.
  if (SEG_CYCLES < 1)
  begin : g_bad_len
    $error("SEG_CYCLES must be at least one.");
  end

  logic [CW-1:0] div_q;
  logic [CW-1:0] div_d;
  logic tick_d;
  logic [7:0] cnt_d;

  // The count wraps by its own width, so 256 segments form one interval.
  always_comb
  begin
    tick_d = (div_q == DIV_LAST);
    div_d = tick_d ? '0 : div_q + CW'(1);
    cnt_d = tick_d ? seg_count_q + 8'h01 : seg_count_q;
  end

  // Registers only.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      div_q <= '0;
      seg_tick_q <= 1'b0;
      seg_count_q <= 8'h00;
    end
    else
    begin
      div_q <= div_d;
      seg_tick_q <= tick_d;
      seg_count_q <= cnt_d;
    end
  end
endmodule : cpsr_seg_timer
`default_nettype wire

// file: verification/cpsr_host_model.sv
// Purpose: Host processor model for the charge period register bank.
// Assumes: Command byte then one data byte; write strobes held 6 clocks.
// Notes: Raises hung when the device never answers a read.
`timescale 1ns/1ps
`default_nettype none
module cpsr_host_model (
  input wire logic core_clk,
  output var cpsr_pkg::cpsr_host_t host_o,
  input wire logic [7:0] host_data_o,
  input wire logic host_data_oe,
  output var logic hung
);
  import cpsr_pkg::*;

  // Idle pins: strobes high, command select, no hang seen.
  initial
  begin
    host_o = '{sel_data: 1'b0, wr_n: 1'b1, rd_n: 1'b1, data: 8'h00};
    hung = 1'b0;
  end

  task automatic cycle(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cycle

  // One write strobe; data stays put well past the filter, then flips.
  task automatic put(input logic sel, input logic [7:0] d);
    @(posedge core_clk);
    host_o.sel_data <= sel;
    host_o.data <= d;
    cycle(2);
    host_o.wr_n <= 1'b0;
    cycle(6);
    host_o.wr_n <= 1'b1;
    cycle(10);
    host_o.data <= ~d; // Released bus must not keep the old byte.
  endtask : put

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    put(1'b0, {3'h5, a});
    put(1'b1, d);
  endtask : wr

  // Read: select settles two clocks before the strobe falls, because the
  // device qualifies the filtered falling strobe with the filtered select.
  // Waits on the enable are bounded so a dead device cannot hang us.
  task automatic fetch(input logic [7:0] cmd, output logic [7:0] d);
    int n;
    d = 8'h00;
    put(1'b0, cmd);
    @(posedge core_clk);
    host_o.sel_data <= 1'b1;
    cycle(2);
    host_o.rd_n <= 1'b0;
    n = 0;
    while (host_data_oe !== 1'b1 && n < 40)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    d = host_data_o;
    @(posedge core_clk);
    host_o.rd_n <= 1'b1;
    while (host_data_oe !== 1'b0 && n < 80)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 40)
      hung = 1'b1;
    cycle(4);
  endtask : fetch

  // Register read: command 011 with the byte address, then the data byte.
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    fetch({3'h3, a}, d);
  endtask : rd
endmodule : cpsr_host_model
`default_nettype wire

// file: verification/testbench.sv
// Purpose: Self-checking bench for the charge period and setup bank.
// Assumes: Segments shortened to 4 clocks so an interval is 1024 clocks.
// Notes: Duty counts are taken over one whole interval.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) \
  begin \
    compares++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("MISMATCH %0t %s", $time, m); \
    end \
  end
module testbench;
  import cpsr_pkg::*;
  localparam int SEG = 4;
  logic core_clk;
  logic rst;
  cpsr_host_t host_in;
  cpsr_stat_t stat_in;
  logic [7:0] host_data_o;
  logic host_data_oe;
  logic [11:0] batt_voltage;
  logic charge_active;
  logic charge_drive_q;
  logic discharge_drive_q;
  logic seg_tick_q;
  logic [11:0] cell_voltage_q;
  cpsr_limits_t limits_q;
  logic [7:0] setup_one_q;
  logic [7:0] seg_count_q;
  logic [7:0] setup_two_q;
  logic [7:0] max_charge_time_q;
  logic [7:0] trickle_period_q;
  logic [7:0] output_mask_q;
  logic [7:0] output_control_q;
  logic [15:0] gauge_threshold_q;
  logic cmd_sys_off_q;
  logic cmd_start_q;
  logic cmd_abort_q;
  int offs = 0;
  int starts = 0;
  int aborts = 0;
  logic hung;
  int mismatches;
  int compares;

  cpsr_top #(.SEG_CYCLES(SEG)) dut (
    .core_clk(core_clk), .rst(rst), .host_in(host_in),
    .host_data_o(host_data_o), .host_data_oe(host_data_oe),
    .stat_in(stat_in), .batt_voltage(batt_voltage),
    .charge_active(charge_active), .charge_drive_q(charge_drive_q),
    .discharge_drive_q(discharge_drive_q), .seg_tick_q(seg_tick_q),
    .seg_count_q(seg_count_q), .cell_voltage_q(cell_voltage_q),
    .limits_q(limits_q), .setup_one_q(setup_one_q),
    .setup_two_q(setup_two_q), .max_charge_time_q(max_charge_time_q),
    .trickle_period_q(trickle_period_q), .output_mask_q(output_mask_q),
    .output_control_q(output_control_q),
    .gauge_threshold_q(gauge_threshold_q), .cmd_sys_off_q(cmd_sys_off_q),
    .cmd_start_q(cmd_start_q), .cmd_abort_q(cmd_abort_q)
  );

  cpsr_host_model host (
    .core_clk(core_clk), .host_o(host_in), .host_data_o(host_data_o),
    .host_data_oe(host_data_oe), .hung(hung)
  );

  always #2.5 core_clk = ~core_clk;

  task automatic test_done;
    if (mismatches == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  // A read that never completes counts against the run and ends it.
  always @(posedge hung)
  begin
    mismatches++;
    test_done();
  end

  // Direct commands leave one-cycle pulses; mid-cycle sampling sees each once.
  always @(negedge core_clk)
  begin
    offs += (cmd_sys_off_q === 1'b1);
    starts += (cmd_start_q === 1'b1);
    aborts += (cmd_abort_q === 1'b1);
  end

  task automatic sc_reset;
    logic [7:0] d;
    `CHK(setup_one_q, 8'h0A, "setup one reset")
    `CHK(cell_voltage_q, 12'h064, "ten cell scale")
    host.rd(5'h01, d);
    `CHK(d, 8'h0A, "setup one read")
  endtask : sc_reset

  task automatic sc_setup;
    logic [7:0] d;
    host.wr(5'h01, 8'hC3);
    `CHK(setup_one_q, 8'hC3, "setup fields")
    host.rd(5'h01, d);
    `CHK(d, 8'hC3, "setup readback")
    `CHK(setup_one_q[3:0], 4'h3, "cell field")
    `CHK(cell_voltage_q, 12'h14D, "three cell voltage")
    host.wr(5'h01, 8'h44);
    host.wr(5'h04, 8'h64);
    host.wr(5'h0C, 8'h8C);
    host.cycle(2);
    `CHK(limits_q.edv_limit, 12'h190, "discharge limit")
    `CHK(limits_q.max_limit, 12'h230, "maximum limit")
    `CHK(cell_voltage_q, 12'h0FA, "four cell voltage")
  endtask : sc_setup

  // The first interval after a write may be partial, so skip it.
  task automatic sc_period(input logic [7:0] cp, input logic [7:0] dp,
                           input int ec, input int ed);
    int c;
    int dc;
    int ov;
    int tk;
    int z;
    host.wr(5'h00, cp);
    host.wr(5'h03, dp);
    host.cycle(256 * SEG);
    c = 0;
    dc = 0;
    ov = 0;
    tk = 0;
    z = 0;
    repeat (256 * SEG)
    begin
      @(posedge core_clk);
      #1;
      c += (charge_drive_q === 1'b1);
      dc += (discharge_drive_q === 1'b1);
      ov += (charge_drive_q === 1'b1 && discharge_drive_q === 1'b1);
      tk += (seg_tick_q === 1'b1);
      z += (seg_count_q === 8'h00);
    end
    `CHK(c, ec, "charge clocks")
    `CHK(dc, ed, "discharge clocks")
    `CHK(ov, 0, "charge and discharge overlap")
    `CHK(tk, 256, "segments per interval")
    `CHK(z, SEG, "segment zero length")
  endtask : sc_period

  // A read-only byte must not take host writes; unmapped bytes read as zero.
  task automatic sc_refused;
    logic [7:0] d;
    host.wr(5'h05, 8'h12);
    host.rd(5'h05, d);
    `CHK(d, 8'hA5, "gauge high kept")
    host.rd(5'h11, d);
    `CHK(d, 8'h00, "unmapped read")
    host.rd(5'h0F, d);
    `CHK(d, 8'h3C, "status byte")
  endtask : sc_refused

  // Remaining bytes, byte storage, direct commands and the action gate.
  task automatic sc_bytes;
    logic [7:0] d;
    int c;
    host.wr(5'h0B, 8'h5A);
    host.wr(5'h10, 8'h21);
    host.wr(5'h0D, 8'h7F);
    host.wr(5'h0E, 8'h05);
    host.wr(5'h07, 8'h12);
    host.wr(5'h08, 8'h34);
    host.wr(5'h02, 8'hFF);
    `CHK(max_charge_time_q, 8'h5A, "max charge time")
    `CHK(trickle_period_q, 8'h21, "trickle period")
    `CHK(output_mask_q, 8'h7F, "output mask")
    `CHK(output_control_q, 8'h05, "output control")
    `CHK(gauge_threshold_q, 16'h1234, "gauge threshold")
    `CHK(setup_two_q, 8'h0F, "setup two writable bits")
    host.rd(5'h02, d);
    `CHK(d, 8'h0F, "setup two read")
    host.put(1'b0, {3'h4, 5'h1F});
    host.put(1'b1, 8'h96);
    host.fetch({3'h2, 5'h1F}, d);
    `CHK(d, 8'h96, "byte storage read")
    host.put(1'b0, 8'h20);
    host.put(1'b0, 8'hC0);
    host.put(1'b0, 8'hE0);
    `CHK(offs, 1, "system off pulse")
    `CHK(starts, 1, "start pulse")
    `CHK(aborts, 1, "abort pulse")
    host.wr(5'h00, 8'hFF);
    host.cycle(4);
    `CHK(charge_drive_q, 1'b1, "full period drive")
    charge_active <= 1'b0;
    host.cycle(3);
    c = 0;
    repeat (64)
    begin
      @(posedge core_clk);
      #1;
      c += (charge_drive_q === 1'b1);
    end
    `CHK(c, 0, "charge without action")
    host.cycle(1);
    charge_active <= 1'b1;
  endtask : sc_bytes

  // Reset for three clocks, let the pin filter settle, then run.
  initial
  begin
    core_clk = 1'b0;
    rst = 1'b1;
    stat_in = '{status: 8'h3C, gauge: 16'hA55A, last_cap: 16'h1234,
                br: 1'b0, gauge_invalid_flag: 1'b0};
    batt_voltage = 12'h3E8;
    charge_active = 1'b1;
    mismatches = 0;
    compares = 0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    host.cycle(6);
    sc_reset();
    sc_setup();
    sc_period(8'h02, 8'h03, 3 * SEG, 3 * SEG);
    sc_period(8'hFF, 8'h00, 256 * SEG, 0);
    sc_period(8'h00, 8'h00, SEG, 0);
    sc_refused();
    sc_bytes();
    test_done();
  end
endmodule : testbench
`default_nettype wire
